/* File: sim/swire_master.sv */
// Behavioural single-wire bus master that opens every bit slot
`timescale 1ns/1ps

module swire_master (
   input  wire logic sys_clk_in,
   input  wire logic line_in,
   output logic      pull_out
);
   initial pull_out <= 1'b0;

   // ==========================================================
   // Slot helpers
   task automatic wait_high();
      for (int i = 0; i < 400 && line_in !== 1'b1; i++) @(posedge sys_clk_in);
      repeat (20) @(posedge sys_clk_in);
   endtask

   // Long high time, start or stop
   task automatic gap();
      repeat (520) @(posedge sys_clk_in);
   endtask

   // Long low time, line reset
   task automatic hold_low(input int n);
      @(posedge sys_clk_in) pull_out <= 1'b1;
      repeat (n) @(posedge sys_clk_in);
      pull_out <= 1'b0;
      wait_high();
   endtask

   // Short low for one, long low for zero
   task automatic wr_bit(input logic b);
      @(posedge sys_clk_in) pull_out <= 1'b1;
      repeat (b ? 20 : 150) @(posedge sys_clk_in);
      pull_out <= 1'b0;
      wait_high();
   endtask

   // Open the slot, release, then sample the line
   task automatic rd_bit(output logic b);
      @(posedge sys_clk_in) pull_out <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      pull_out <= 1'b0;
      repeat (50) @(posedge sys_clk_in);
      b = line_in;
      wait_high();
   endtask

   // Address and memory bytes, msb first
   task automatic wr_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--) wr_bit(v[i]);
   endtask

   task automatic rd_byte(output logic [7:0] v);
      for (int i = 7; i >= 0; i--) rd_bit(v[i]);
   endtask
endmodule

/* File: sim/swire_read_slave_tb.sv */
// Testbench of the single-wire read slave
`timescale 1ns/1ps

module swire_read_slave_tb;
   // Identity and serial values are arbitrary
   localparam logic [7:0]  PID   = 8'h5c;
   localparam logic [47:0] UNI   = 48'h0123456789ab;
   localparam logic [11:0] MAKER = 12'h123;
   localparam logic [8:0]  DEV   = 9'h0a5;
   localparam logic [2:0]  REV   = 3'h1;
   localparam int          LIMIT = 90000;
   localparam logic [23:0] ID    = {MAKER, DEV, REV};

   logic                    sys_clk;
   logic                    rst_n;
   logic                    sio;
   logic                    sio_o;
   logic                    sio_oe;
   logic                    pull;
   logic                    busy;
   logic [7:0]              mem_data;
   swire_read_pkg::rd_req_t rd_req;
   int                      miscompares;
   int                      n_tests;
   int                      cycles = 0;

   // ==========================================================
   // Clock, line and memory
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   assign sio = ~(pull | (sio_oe & ~sio_o));
   assign mem_data = memv(rd_req.sec, rd_req.addr);

   function automatic logic [7:0] memv(input logic s, input logic [6:0] a);
      return {s, a} ^ 8'h5a;
   endfunction

   function automatic logic [7:0] crc7();
      logic [7:0] c;
      logic [7:0] d;
      c = 8'h00;
      for (int k = 0; k < 7; k++) begin
         d = (k == 0) ? PID : UNI[55-8*k -: 8];
         for (int j = 0; j < 8; j++)
            c = (c >> 1) ^ ((c[0] ^ d[j]) ? 8'h8c : 8'h00);
      end
      return c;
   endfunction

   swire_read_slave #(
      .PRODUCT_ID  (PID),
      .UNIQUE_NUM  (UNI),
      .MAKER_CODE  (MAKER),
      .DEVICE_CODE (DEV),
      .REVISION    (REV)
   ) uut (
      .sys_clk_in  (sys_clk),
      .rst_n_in    (rst_n),
      .sio_in      (sio),
      .sio_out     (sio_o),
      .sio_oe_out  (sio_oe),
      .rd_req_out  (rd_req),
      .mem_data_in (mem_data),
      .busy_out    (busy)
   );

   swire_master m (
      .sys_clk_in (sys_clk),
      .line_in    (sio),
      .pull_out   (pull)
   );

   // ==========================================================
   // Checking and closing
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares++;
         end_of_test();
      end
   end

   // ==========================================================
   // Frame helpers
   task automatic addr_frame(input logic [3:0] op, input logic rw,
                             output logic ak);
      m.gap();
      m.wr_byte({op, 3'h0, rw});
      m.rd_bit(ak);
   endtask

   task automatic dummy(input logic [3:0] op, input logic [7:0] a);
      logic ak;
      addr_frame(op, 1'b0, ak);
      check({7'h0, ak}, 8'h00);
      m.wr_byte(a);
      m.rd_bit(ak);
      check({7'h0, ak}, 8'h00);
   endtask

   task automatic get(input logic [7:0] exp, input logic last);
      logic [7:0] b;
      m.rd_byte(b);
      check(b, exp);
      m.wr_bit(last);
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_random_main();
      logic ak;
      dummy(swire_read_pkg::OP_MAIN, 8'h7e);
      addr_frame(swire_read_pkg::OP_MAIN, 1'b1, ak);
      check({7'h0, ak}, 8'h00);
      get(memv(1'b0, 7'h7e), 1'b0);
      get(memv(1'b0, 7'h7f), 1'b0);
      get(memv(1'b0, 7'h00), 1'b1);
   endtask

   task automatic t_current();
      logic ak;
      repeat (30) @(posedge sys_clk);
      check({7'h0, busy}, 8'h00);
      addr_frame(swire_read_pkg::OP_MAIN, 1'b1, ak);
      check({7'h0, ak}, 8'h00);
      get(memv(1'b0, 7'h01), 1'b1);
   endtask

   task automatic t_security();
      logic ak;
      dummy(swire_read_pkg::OP_SEC, 8'hff);
      addr_frame(swire_read_pkg::OP_SEC, 1'b1, ak);
      check({7'h0, ak}, 8'h00);
      get(memv(1'b1, 7'h1f), 1'b0);
      get(PID, 1'b0);
      for (int i = 0; i < 6; i++) get(UNI[47-8*i -: 8], 1'b0);
      get(crc7(), 1'b0);
      get(swire_read_pkg::SEC_FILL, 1'b1);
   endtask

   task automatic t_ident();
      logic ak;
      addr_frame(swire_read_pkg::OP_ID, 1'b1, ak);
      check({7'h0, ak}, 8'h00);
      get(ID[23:16], 1'b0);
      get(ID[15:8], 1'b0);
      get(ID[7:0], 1'b0);
      get(ID[23:16], 1'b1);
      addr_frame(swire_read_pkg::OP_ID, 1'b0, ak);
      check({7'h0, ak}, 8'h01);
   endtask

   task automatic t_line_reset();
      logic ak;
      m.hold_low(2450);
      addr_frame(swire_read_pkg::OP_MAIN, 1'b1, ak);
      check({7'h0, ak}, 8'h00);
      get(memv(1'b0, 7'h00), 1'b1);
   endtask

   initial begin
      miscompares = 0;
      n_tests = 0;
      rst_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_random_main();
      t_current();
      t_security();
      t_ident();
      t_line_reset();
      m.gap();
      end_of_test();
   end
endmodule

/* File: src/serial_crc8.sv */
// CRC over the seven leading serial-number bytes
`timescale 1ns/1ps

module serial_crc8 #(
   parameter int unsigned NBYTES = 7
) (
   input  wire logic [NBYTES*8-1:0] data_in,
   output logic      [7:0]          crc_out
);

   // ==========================================================
   // Bitwise reflected CRC, byte 0 first, lsb first
   always_comb begin
      logic [7:0] acc;
      logic       fb;
      acc = 8'h00;
      fb  = 1'b0;
      for (int i = 0; i < NBYTES * 8; i++) begin
         fb  = acc[0] ^ data_in[(NBYTES - 1 - i / 8) * 8 + i % 8];
         acc = {1'b0, acc[7:1]};
         if (fb) begin
            acc = acc ^ swire_read_pkg::CRC_POLY_REV;
         end
      end
      crc_out = acc;
   end

endmodule

/* File: src/swire_read_pkg.sv */
// Shared constants, types and states of the single-wire read slave
package swire_read_pkg;

   // ==========================================================
   // Clock and bit-slot timing
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned T_BIT_THRESH_NS = 4000;
   localparam int unsigned T_HOLD_NS       = 8000;
   localparam int unsigned T_IDLE_NS       = 20000;
   localparam int unsigned T_RESET_NS      = 96000;

   localparam logic [11:0] BIT_THRESH_CYC =
      12'((T_BIT_THRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] HOLD_CYC =
      12'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] IDLE_CYC =
      12'((T_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [11:0] RESET_CYC =
      12'((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // ==========================================================
   // Opcodes and address layout
   localparam logic [3:0] OP_MAIN = 4'ha;
   localparam logic [3:0] OP_SEC  = 4'hb;
   localparam logic [3:0] OP_ID   = 4'hc;

   localparam logic [6:0] MAIN_LAST   = 7'h7f;
   localparam logic [4:0] SEC_LAST    = 5'h1f;
   localparam logic [4:0] SEC_CRC_IDX = 5'h07;
   localparam logic [4:0] SEC_FF_LO   = 5'h08;
   localparam logic [4:0] SEC_FF_HI   = 5'h0f;
   localparam logic [7:0] SEC_FILL    = 8'hff;
   localparam logic [1:0] ID_LAST_IDX = 2'h2;
   localparam logic [7:0] CRC_POLY_REV = 8'h8c;

   // ==========================================================
   // Types
   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_DEVADDR = 7'h02,
      ST_ACK_DEV = 7'h04,
      ST_MEMADDR = 7'h08,
      ST_ACK_MEM = 7'h10,
      ST_TX      = 7'h20,
      ST_RX_ACK  = 7'h40
   } slot_state_t;

   typedef struct packed {
      logic       sec;
      logic [6:0] addr;
   } rd_req_t;

endpackage

/* File: src/swire_read_slave.sv */
// Single-wire serial memory slave, read side
`timescale 1ns/1ps

// Contract
// - One pointer serves main array and security area, pointing past last.
// - Pointer wraps to the start of its own region at the end.
// - Pointer keeps its value between operations until reset.
// - Current-address read, opcode 1010b read bit one, device acks with zero.
// - Master opens each data slot; device holds low for zero bits.
// - Master nack ends read to standby; master ack asks next byte.
// - Sequential read increments pointer per byte sent until a nack.
// - Random read: write-form address and memory byte load pointer.
// - Security area read with opcode 1011b after a dummy write.
// - Security addressing ignores the three top memory address bits.
// - Serial byte zero product code, bytes one-six unique, byte seven check.
// - Check byte is CRC x^8+x^5+x^4+1 over first seven bytes.
// - Ack after serial byte seven continues at eight, wraps at end.
// - Identity read, opcode 1100b read bit one, device acks with zero.
// - Identity opcode with read bit zero is not acknowledged.
// - Identity sent msb byte first, wraps after third byte, nack ends.
// - Identity fields: maker code, density code, revision.
// - Device acks address and memory byte of a main or security write form with zero.
module swire_read_slave #(
   parameter logic [2:0]  SLAVE_ADDR  = 3'h0,
   parameter logic [7:0]  PRODUCT_ID  = 8'h5c,          // Arbitrary value
   parameter logic [47:0] UNIQUE_NUM  = 48'h0123456789ab,
   parameter logic [11:0] MAKER_CODE  = 12'h123,        // Arbitrary value
   parameter logic [8:0]  DEVICE_CODE = 9'h0a5,         // Arbitrary value
   parameter logic [2:0]  REVISION    = 3'h1            // Arbitrary value
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic                    sio_in,
   output logic                         sio_out,
   output logic                         sio_oe_out,
   output swire_read_pkg::rd_req_t      rd_req_out,
   input  wire logic [7:0]              mem_data_in,
   output logic                         busy_out
);

   // ==========================================================
   // Declarations
   logic                        sync1_reg;
   logic                        sync2_reg;
   logic                        line_prev_reg;
   logic [11:0]                 low_cnt_reg;
   logic [11:0]                 high_cnt_reg;
   logic                        start_pend_reg;
   swire_read_pkg::slot_state_t st_reg;
   logic [2:0]                  bit_cnt_reg;
   logic [6:0]                  shift_reg;
   logic [3:0]                  op_reg;
   logic                        rw_reg;
   logic                        ack_val_reg;
   logic [6:0]                  ptr_reg;
   logic [1:0]                  id_idx_reg;
   logic [7:0]                  tx_reg;
   logic [11:0]                 hold_cnt_reg;
   logic                        fall;
   logic                        rise;
   logic                        bit_val;
   logic                        stop_ev;
   logic                        line_rst;
   logic [7:0]                  rx_byte;
   logic                        ack_ok;
   logic                        dev_done;
   logic                        mem_done;
   logic                        byte_done;
   logic                        drive_zero;
   logic [7:0]                  byte_sel;
   logic [7:0]                  sec_byte;
   logic [7:0]                  crc_val;
   logic [23:0]                 id_word;

   // ==========================================================
   // Pin synchroniser and slot timing
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sync1_reg     <= 1'b1;
         sync2_reg     <= 1'b1;
         line_prev_reg <= 1'b1;
      end else begin
         sync1_reg     <= sio_in;
         sync2_reg     <= sync1_reg;
         line_prev_reg <= sync2_reg;
      end
   end

   assign fall     = line_prev_reg & ~sync2_reg;
   assign rise     = ~line_prev_reg & sync2_reg;
   assign bit_val  = low_cnt_reg < swire_read_pkg::BIT_THRESH_CYC;
   assign stop_ev  = sync2_reg && line_prev_reg &&
                     high_cnt_reg == swire_read_pkg::IDLE_CYC - 12'h001;
   assign line_rst = ~sync2_reg &&
                     low_cnt_reg == swire_read_pkg::RESET_CYC - 12'h001;

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         low_cnt_reg  <= 12'h000;
         high_cnt_reg <= 12'h000;
      end else if (sync2_reg) begin
         if (fall || rise) begin
            high_cnt_reg <= 12'h001;
         end else if (high_cnt_reg != 12'hfff) begin
            high_cnt_reg <= high_cnt_reg + 12'h001;
         end
         if (!line_prev_reg) begin
            low_cnt_reg <= low_cnt_reg;
         end else begin
            low_cnt_reg <= 12'h000;
         end
      end else begin
         if (fall) begin
            low_cnt_reg <= 12'h001;
         end else if (low_cnt_reg != 12'hfff) begin
            low_cnt_reg <= low_cnt_reg + 12'h001;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         start_pend_reg <= 1'b0;
      end else if (stop_ev) begin
         start_pend_reg <= 1'b1;
      end else if (rise) begin
         start_pend_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Address byte decode
   assign rx_byte  = {shift_reg, bit_val};
   assign ack_ok   = rx_byte[3:1] == SLAVE_ADDR &&
                     (rx_byte[7:4] == swire_read_pkg::OP_MAIN ||
                      rx_byte[7:4] == swire_read_pkg::OP_SEC  ||
                      (rx_byte[7:4] == swire_read_pkg::OP_ID &&
                       rx_byte[0]));
   assign dev_done = rise && !start_pend_reg &&
                     st_reg == swire_read_pkg::ST_DEVADDR &&
                     bit_cnt_reg == 3'h7;
   assign mem_done = rise && !start_pend_reg &&
                     st_reg == swire_read_pkg::ST_MEMADDR &&
                     bit_cnt_reg == 3'h7;
   assign byte_done = rise && !start_pend_reg &&
                      st_reg == swire_read_pkg::ST_TX &&
                      bit_cnt_reg == 3'h7;

   // ==========================================================
   // Slot state machine
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || line_rst) begin
         st_reg      <= swire_read_pkg::ST_IDLE;
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 7'h00;
         op_reg      <= 4'h0;
         rw_reg      <= 1'b0;
         ack_val_reg <= 1'b1;
      end else if (stop_ev) begin
         st_reg <= swire_read_pkg::ST_IDLE;
      end else if (rise && start_pend_reg) begin
         st_reg      <= swire_read_pkg::ST_DEVADDR;
         shift_reg   <= {6'h00, bit_val};
         bit_cnt_reg <= 3'h1;
      end else if (rise) begin
         case (st_reg)
            swire_read_pkg::ST_DEVADDR: begin
               shift_reg   <= rx_byte[6:0];
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  op_reg      <= rx_byte[7:4];
                  rw_reg      <= rx_byte[0];
                  ack_val_reg <= ~ack_ok;
                  st_reg      <= swire_read_pkg::ST_ACK_DEV;
               end
            end
            swire_read_pkg::ST_ACK_DEV: begin
               bit_cnt_reg <= 3'h0;
               if (ack_val_reg) begin
                  st_reg <= swire_read_pkg::ST_IDLE;
               end else if (!rw_reg) begin
                  st_reg <= swire_read_pkg::ST_MEMADDR;
               end else begin
                  st_reg <= swire_read_pkg::ST_TX;
               end
            end
            swire_read_pkg::ST_MEMADDR: begin
               shift_reg   <= rx_byte[6:0];
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  ack_val_reg <= 1'b0;
                  st_reg      <= swire_read_pkg::ST_ACK_MEM;
               end
            end
            swire_read_pkg::ST_ACK_MEM: begin
               st_reg <= swire_read_pkg::ST_IDLE;
            end
            swire_read_pkg::ST_TX: begin
               bit_cnt_reg <= bit_cnt_reg + 3'h1;
               if (bit_cnt_reg == 3'h7) begin
                  st_reg <= swire_read_pkg::ST_RX_ACK;
               end
            end
            swire_read_pkg::ST_RX_ACK: begin
               bit_cnt_reg <= 3'h0;
               if (bit_val) begin
                  st_reg <= swire_read_pkg::ST_IDLE;
               end else begin
                  st_reg <= swire_read_pkg::ST_TX;
               end
            end
            default: begin
               st_reg <= swire_read_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Shared address pointer
   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || line_rst) begin
         ptr_reg <= 7'h00;
      end else if (mem_done) begin
         if (op_reg == swire_read_pkg::OP_SEC) begin
            ptr_reg <= {2'h0, rx_byte[4:0]};
         end else begin
            ptr_reg <= rx_byte[6:0];
         end
      end else if (byte_done && op_reg == swire_read_pkg::OP_SEC) begin
         if (ptr_reg[4:0] == swire_read_pkg::SEC_LAST) begin
            ptr_reg <= 7'h00;
         end else begin
            ptr_reg <= {2'h0, ptr_reg[4:0] + 5'h01};
         end
      end else if (byte_done && op_reg == swire_read_pkg::OP_MAIN) begin
         if (ptr_reg == swire_read_pkg::MAIN_LAST) begin
            ptr_reg <= 7'h00;
         end else begin
            ptr_reg <= ptr_reg + 7'h01;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || dev_done) begin
         id_idx_reg <= 2'h0;
      end else if (byte_done && op_reg == swire_read_pkg::OP_ID) begin
         if (id_idx_reg == swire_read_pkg::ID_LAST_IDX) begin
            id_idx_reg <= 2'h0;
         end else begin
            id_idx_reg <= id_idx_reg + 2'h1;
         end
      end
   end

   // ==========================================================
   // Byte sources
   serial_crc8 #(
      .NBYTES (7)
   ) u_crc (
      .data_in (({PRODUCT_ID, UNIQUE_NUM})),
      .crc_out (crc_val)
   );

   assign id_word = {MAKER_CODE, DEVICE_CODE, REVISION};

   always_comb begin
      sec_byte = mem_data_in;
      if (ptr_reg[4:0] == 5'h00) begin
         sec_byte = PRODUCT_ID;
      end else if (ptr_reg[4:0] < swire_read_pkg::SEC_CRC_IDX) begin
         sec_byte = UNIQUE_NUM[8'(6 - ptr_reg[2:0]) * 8 +: 8];
      end else if (ptr_reg[4:0] == swire_read_pkg::SEC_CRC_IDX) begin
         sec_byte = crc_val;
      end else if (ptr_reg[4:0] >= swire_read_pkg::SEC_FF_LO &&
                   ptr_reg[4:0] <= swire_read_pkg::SEC_FF_HI) begin
         sec_byte = swire_read_pkg::SEC_FILL;
      end
   end

   always_comb begin
      if (op_reg == swire_read_pkg::OP_ID) begin
         byte_sel = id_word[8'(2 - id_idx_reg) * 8 +: 8];
      end else if (op_reg == swire_read_pkg::OP_SEC) begin
         byte_sel = sec_byte;
      end else begin
         byte_sel = mem_data_in;
      end
   end

   // ==========================================================
   // Line drive for acks and data zeros
   always_comb begin
      drive_zero = 1'b0;
      if ((st_reg == swire_read_pkg::ST_ACK_DEV ||
           st_reg == swire_read_pkg::ST_ACK_MEM) && !ack_val_reg) begin
         drive_zero = 1'b1;
      end else if (st_reg == swire_read_pkg::ST_TX) begin
         if (bit_cnt_reg == 3'h0) begin
            drive_zero = ~byte_sel[7];
         end else begin
            drive_zero = ~tx_reg[3'h7 - bit_cnt_reg];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         tx_reg <= 8'h00;
      end else if (fall && st_reg == swire_read_pkg::ST_TX &&
                   bit_cnt_reg == 3'h0) begin
         tx_reg <= byte_sel;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in || line_rst) begin
         hold_cnt_reg <= 12'h000;
         sio_oe_out   <= 1'b0;
      end else if (fall && drive_zero) begin
         hold_cnt_reg <= swire_read_pkg::HOLD_CYC - 12'h001;
         sio_oe_out   <= 1'b1;
      end else if (hold_cnt_reg != 12'h000) begin
         hold_cnt_reg <= hold_cnt_reg - 12'h001;
      end else begin
         sio_oe_out <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
         sio_out    <= 1'b0;
         rd_req_out <= '0;
         busy_out   <= 1'b0;
      end else begin
         sio_out         <= 1'b0;
         rd_req_out.sec  <= op_reg == swire_read_pkg::OP_SEC;
         rd_req_out.addr <= ptr_reg;
         busy_out        <= st_reg != swire_read_pkg::ST_IDLE;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);

   sequence zero_slot_s;
      fall && drive_zero;
   endsequence

   sequence held_low_s;
      sio_oe_out [*8];
   endsequence

   main_ptr_wrap_a: assert property (byte_done && !line_rst &&
      op_reg == swire_read_pkg::OP_MAIN && ptr_reg == 7'h7f
      |=> ptr_reg == 7'h00) else $error("main pointer did not wrap");

   sec_ptr_wrap_a: assert property (byte_done && !line_rst &&
      op_reg == swire_read_pkg::OP_SEC && ptr_reg[4:0] == 5'h1f
      |=> ptr_reg == 7'h00) else $error("security pointer did not wrap");

   ptr_retained_a: assert property (!mem_done && !byte_done &&
      !line_rst |=> $stable(ptr_reg)) else $error("pointer changed");

   zero_drive_a: assert property (zero_slot_s |=> held_low_s)
      else $error("zero bit not held low");

   id_write_nack_a: assert property (dev_done && !line_rst &&
      rx_byte[7:4] == swire_read_pkg::OP_ID && !rx_byte[0]
      |=> ack_val_reg && st_reg == swire_read_pkg::ST_ACK_DEV)
      else $error("identity write form was acked");

   nack_standby_a: assert property (rise && !start_pend_reg &&
      !line_rst && st_reg == swire_read_pkg::ST_RX_ACK && bit_val
      |=> st_reg == swire_read_pkg::ST_IDLE)
      else $error("nack did not end read");

   ack_next_byte_a: assert property (rise && !start_pend_reg &&
      !line_rst && !stop_ev && st_reg == swire_read_pkg::ST_RX_ACK &&
      !bit_val |=> st_reg == swire_read_pkg::ST_TX && bit_cnt_reg == 3'h0)
      else $error("ack did not start next byte");

   sec_addr_mask_a: assert property (mem_done && !line_rst &&
      op_reg == swire_read_pkg::OP_SEC |=> ptr_reg[6:5] == 2'h0)
      else $error("security address top bits kept");

   id_idx_wrap_a: assert property (byte_done &&
      op_reg == swire_read_pkg::OP_ID && id_idx_reg == 2'h2
      |=> id_idx_reg == 2'h0) else $error("identity index did not wrap");

   ack_drive_a: assert property (fall && !line_rst &&
      st_reg == swire_read_pkg::ST_ACK_DEV && !ack_val_reg
      |=> sio_oe_out ##1 sio_oe_out)
      else $error("address ack not driven");

endmodule
